// file: rtl/ssc_pkg.sv
// Shared constants and types for the converter control and serial output.
package ssc_pkg;

	// Result width and reset value of the result registers.
	localparam int RES_W = 16;
	localparam logic [15:0] RESULT_RST = 16'h0000;

	// Top bit index of the approximation sequence.
	localparam logic [3:0] BIT_TOP = 4'hf;

	// Phases of one internal shift clock pulse, one core cycle each.
	localparam logic [1:0] PH_DATA = 2'h0;
	localparam logic [1:0] PH_HIGH = 2'h1;
	localparam logic [1:0] PH_LOW = 2'h2;

	// Conversion sequencer states.
	typedef enum logic [0:0] {
		ST_IDLE,
		ST_CONV
	} ssc_state_t;

	// Host-side pins, carried together through the core synchroniser.
	typedef struct packed {
		logic rd_conv;
		logic chip_sel_n;
		logic power_down;
		logic output_format_sel;
		logic shift_clock_source_sel;
		logic tag;
	} ssc_pins_t;

	// Synchroniser reset loads the released strobe levels, so that no
	// false start edge follows reset.
	localparam ssc_pins_t PINS_RST = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0};

	// Levels carried into the shift clock domain.
	typedef struct packed {
		logic rd_en;
		logic ext_mode;
	} ssc_link_ctl_t;

endpackage : ssc_pkg

// file: rtl/ssc_sar_serial_control.sv
// Conversion sequencer and serial result output of the converter.
// Notes on behaviour
// - Format high gives straight binary, low two's complement.
// - Source select high: host clocks the shift.
// - Internal mode: convert sends previous result, 16 pulses.
// - Internal mode: 16 pulses per conversion, else low.
// - External mode: read enable edge gives sync pulse.
// - External mode: tag follows result, 16 clocks later.
// - Internal mode: data stable over both clock edges.
// - Internal mode: idle data holds tag level from conversion start.
// - Read/convert falling with select low starts conversion.
// - External mode: read/convert rising with select low enables output.
// - Select ORed with read/convert for the convert edge; output enable is read/convert high ANDed with select low.
// - Status low during conversion; result valid on rise.
// - Start level still low at end restarts immediately.
// - Power down inhibits conversions, keeps old result.
// - Start clears approximation; busy ignores new starts.
// - Bits resolved from most to least significant.
// - End of conversion loads result register; next start loads shift register.
`timescale 1ns/1ns

module ssc_sar_serial_control #(
	parameter int RES_W = ssc_pkg::RES_W
) (
	input wire logic core_clk_i,
	input wire logic sys_rst_i,
	input wire logic rd_conv_i,
	input wire logic chip_sel_n_i,
	input wire logic power_down_i,
	input wire logic output_format_sel_i,
	input wire logic shift_clock_source_sel_i,
	input wire logic tag_i,
	input wire logic comparator_i,
	input wire logic shift_clock_i,
	output logic shift_clock_o,
	output logic shift_clock_oe_o,
	output logic data_o,
	output logic sync_o,
	output logic idle_o,
	output logic hold_o,
	output logic [RES_W-1:0] dac_code_o
);

	// Core domain: pin synchroniser.
	ssc_pkg::ssc_pins_t pin_s1_r;
	ssc_pkg::ssc_pins_t pin_s2_r;
	ssc_pkg::ssc_pins_t pin_in;

	always_comb begin
		pin_in.rd_conv = rd_conv_i;
		pin_in.chip_sel_n = chip_sel_n_i;
		pin_in.power_down = power_down_i;
		pin_in.output_format_sel = output_format_sel_i;
		pin_in.shift_clock_source_sel = shift_clock_source_sel_i;
		pin_in.tag = tag_i;
	end

	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i) begin
			pin_s1_r <= ssc_pkg::PINS_RST;
			pin_s2_r <= ssc_pkg::PINS_RST;
		end else begin
			pin_s1_r <= pin_in;
			pin_s2_r <= pin_s1_r;
		end
	end

	// Core domain: sequencer state.
	ssc_pkg::ssc_state_t state_r, state_nxt;
	logic [1:0] ph_r, ph_nxt;
	logic [3:0] bit_r, bit_nxt;
	logic [RES_W-1:0] approx_r, approx_nxt;
	logic [RES_W-1:0] res_word_r, res_word_nxt;
	logic res_tgl_r, res_tgl_nxt;
	logic [RES_W-1:0] int_sh_r, int_sh_nxt;
	logic int_data_r, int_data_nxt;
	logic tag_hold_r, tag_hold_nxt;
	logic sclk_r, sclk_nxt;
	logic conv_prev_r, conv_prev_nxt;
	logic just_done_r, just_done_nxt;
	logic conv_lvl;
	logic start;
	logic last_step;
	logic ext_mode;

	always_comb begin
		// Both strobes low is the convert level; its rise starts.
		conv_lvl = ~(pin_s2_r.chip_sel_n | pin_s2_r.rd_conv);
		ext_mode = pin_s2_r.shift_clock_source_sel;
		// A start level still present right after completion restarts.
		start = (state_r == ssc_pkg::ST_IDLE) && conv_lvl &&
			!pin_s2_r.power_down &&
			(!conv_prev_r || just_done_r);
		last_step = (ph_r == ssc_pkg::PH_LOW) && (bit_r == 4'h0);

		state_nxt = state_r;
		ph_nxt = ph_r;
		bit_nxt = bit_r;
		approx_nxt = approx_r;
		res_word_nxt = res_word_r;
		res_tgl_nxt = res_tgl_r;
		int_sh_nxt = int_sh_r;
		int_data_nxt = int_data_r;
		tag_hold_nxt = tag_hold_r;
		sclk_nxt = 1'b0;
		conv_prev_nxt = conv_lvl;
		just_done_nxt = 1'b0;

		unique case (state_r)
			ssc_pkg::ST_IDLE: begin
				if (start) begin
					state_nxt = ssc_pkg::ST_CONV;
					ph_nxt = ssc_pkg::PH_DATA;
					bit_nxt = ssc_pkg::BIT_TOP;
					approx_nxt = '0;
					tag_hold_nxt = pin_s2_r.tag;
					// The previous result leaves first, MSB leading.
					int_data_nxt = res_word_r[RES_W-1];
					int_sh_nxt = {res_word_r[RES_W-2:0], 1'b0};
				end
			end
			ssc_pkg::ST_CONV: begin
				unique case (ph_r)
					ssc_pkg::PH_DATA: begin
						ph_nxt = ssc_pkg::PH_HIGH;
						sclk_nxt = 1'b1;
					end
					ssc_pkg::PH_HIGH: begin
						ph_nxt = ssc_pkg::PH_LOW;
					end
					default: begin
						// Data changes only a cycle after the falling edge,
						// so it is steady across both edges of each pulse.
						ph_nxt = ssc_pkg::PH_DATA;
						approx_nxt[bit_r] = comparator_i;
						bit_nxt = bit_r - 4'h1;
						int_data_nxt = int_sh_r[RES_W-1];
						int_sh_nxt = {int_sh_r[RES_W-2:0], 1'b0};
						if (last_step) begin
							state_nxt = ssc_pkg::ST_IDLE;
							just_done_nxt = 1'b1;
							int_data_nxt = tag_hold_r;
							// Straight binary keeps the MSB, two's
							// complement inverts it.
							res_word_nxt = {approx_r[RES_W-1] ^
								~pin_s2_r.output_format_sel,
								approx_r[RES_W-2:1],
								comparator_i};
							res_tgl_nxt = ~res_tgl_r;
						end
					end
				endcase
			end
		endcase
	end

	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i) begin
			state_r <= ssc_pkg::ST_IDLE;
			ph_r <= ssc_pkg::PH_DATA;
			bit_r <= ssc_pkg::BIT_TOP;
			approx_r <= ssc_pkg::RESULT_RST;
			res_word_r <= ssc_pkg::RESULT_RST;
			res_tgl_r <= 1'b0;
			int_sh_r <= ssc_pkg::RESULT_RST;
			int_data_r <= 1'b0;
			tag_hold_r <= 1'b0;
			sclk_r <= 1'b0;
			conv_prev_r <= 1'b1;
			just_done_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			ph_r <= ph_nxt;
			bit_r <= bit_nxt;
			approx_r <= approx_nxt;
			res_word_r <= res_word_nxt;
			res_tgl_r <= res_tgl_nxt;
			int_sh_r <= int_sh_nxt;
			int_data_r <= int_data_nxt;
			tag_hold_r <= tag_hold_nxt;
			sclk_r <= sclk_nxt;
			conv_prev_r <= conv_prev_nxt;
			just_done_r <= just_done_nxt;
		end
	end

	// The trial code sets the bit under test on top of decided bits.
	// It is built from the next state, so the registered code shows
	// each trial in the same cycle as the state that it belongs to.
	logic [RES_W-1:0] dac_r, dac_nxt;

	always_comb begin
		dac_nxt = approx_nxt;
		if (state_nxt == ssc_pkg::ST_CONV) begin
			dac_nxt[bit_nxt] = 1'b1;
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i) begin
			dac_r <= ssc_pkg::RESULT_RST;
		end else begin
			dac_r <= dac_nxt;
		end
	end

	assign dac_code_o = dac_r;

	assign idle_o = (state_r == ssc_pkg::ST_IDLE);
	assign hold_o = (state_r == ssc_pkg::ST_CONV);
	assign shift_clock_o = sclk_r;
	assign shift_clock_oe_o = ~ext_mode;

	// Shift clock domain. Its reset is synchronised here; as the host
	// clock may stand still, reset takes hold at its first edges.
	logic lrst_s1_r;
	logic lrst_r;
	ssc_pkg::ssc_link_ctl_t ctl_in;
	ssc_pkg::ssc_link_ctl_t ctl_s1_r;
	ssc_pkg::ssc_link_ctl_t ctl_s2_r;
	logic tgl_s1_r;
	logic tgl_s2_r;

	always_comb begin
		// Read enable: read/convert high with select low.
		ctl_in.rd_en = rd_conv_i & ~chip_sel_n_i;
		ctl_in.ext_mode = shift_clock_source_sel_i;
	end

	always_ff @(posedge shift_clock_i) begin
		lrst_s1_r <= sys_rst_i;
		lrst_r <= lrst_s1_r;
	end

	always_ff @(posedge shift_clock_i) begin
		if (lrst_r) begin
			ctl_s1_r <= '0;
			ctl_s2_r <= '0;
			tgl_s1_r <= 1'b0;
			tgl_s2_r <= 1'b0;
		end else begin
			ctl_s1_r <= ctl_in;
			ctl_s2_r <= ctl_s1_r;
			tgl_s1_r <= res_tgl_r;
			tgl_s2_r <= tgl_s1_r;
		end
	end

	logic rd_prev_r, rd_prev_nxt;
	logic tgl_seen_r, tgl_seen_nxt;
	logic [RES_W-1:0] lword_r, lword_nxt;
	logic [RES_W-1:0] lsh_r, lsh_nxt;
	logic ldata_r, ldata_nxt;
	logic sync_r, sync_nxt;
	logic rd_rise;

	always_comb begin
		rd_rise = ctl_s2_r.rd_en & ~rd_prev_r;
		rd_prev_nxt = ctl_s2_r.rd_en;
		tgl_seen_nxt = tgl_s2_r;
		lword_nxt = lword_r;
		lsh_nxt = lsh_r;
		ldata_nxt = ldata_r;
		// The result word is steady by the time its toggle arrives.
		if (tgl_s2_r != tgl_seen_r) begin
			lword_nxt = res_word_r;
		end
		sync_nxt = rd_rise & ctl_s2_r.ext_mode;
		// Tag is timed to this clock by the host, so it is sampled
		// directly and emerges after the 16 result bits.
		if (rd_rise) begin
			ldata_nxt = lword_r[RES_W-1];
			lsh_nxt = {lword_r[RES_W-2:0], tag_i};
		end else if (ctl_s2_r.rd_en) begin
			ldata_nxt = lsh_r[RES_W-1];
			lsh_nxt = {lsh_r[RES_W-2:0], tag_i};
		end
	end

	always_ff @(posedge shift_clock_i) begin
		if (lrst_r) begin
			rd_prev_r <= 1'b0;
			tgl_seen_r <= 1'b0;
			lword_r <= ssc_pkg::RESULT_RST;
			lsh_r <= ssc_pkg::RESULT_RST;
			ldata_r <= 1'b0;
			sync_r <= 1'b0;
		end else begin
			rd_prev_r <= rd_prev_nxt;
			tgl_seen_r <= tgl_seen_nxt;
			lword_r <= lword_nxt;
			lsh_r <= lsh_nxt;
			ldata_r <= ldata_nxt;
			sync_r <= sync_nxt;
		end
	end

	assign sync_o = sync_r;
	// The source select is a static strap, so this steering mux sees
	// no change while either path is active.
	assign data_o = ext_mode ? ldata_r : int_data_r;

endmodule : ssc_sar_serial_control

// file: testbench/ssc_chk.sv
// Checker for conversion timing and the serial result output.
`timescale 1ns/1ns
module ssc_chk #(parameter int RES_W = ssc_pkg::RES_W) (
	input wire logic core_clk_i,
	input wire logic sys_rst_i,
	input wire logic rd_conv_i,
	input wire logic chip_sel_n_i,
	input wire logic power_down_i,
	input wire logic output_format_sel_i,
	input wire logic shift_clock_source_sel_i,
	input wire logic tag_i,
	input wire logic comparator_i,
	input wire logic shift_clock_i,
	input wire logic shift_clock_o,
	input wire logic shift_clock_oe_o,
	input wire logic data_o,
	input wire logic sync_o,
	input wire logic idle_o,
	input wire logic hold_o,
	input wire logic [RES_W-1:0] dac_code_o
);
	logic [7:0] busy_cnt_r, busy_cnt_nxt;
	always_comb begin
		busy_cnt_nxt = idle_o ? 8'h00 : busy_cnt_r + 8'h01;
	end
	always_ff @(posedge core_clk_i) begin
		busy_cnt_r <= busy_cnt_nxt;
	end
	chk_busy_len:
	assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
		$rose(idle_o) |-> busy_cnt_r == 8'h30) else $error("busy length");
	chk_start_clear:
	assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
		$fell(idle_o) |-> dac_code_o == {1'b1, {(RES_W-1){1'b0}}})
		else $error("start code");
	chk_msb_first:
	assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
		$fell(idle_o) |-> ##3 dac_code_o[RES_W-2] &&
		dac_code_o[RES_W-3:0] == '0) else $error("bit order");
	chk_clk_rest:
	assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
		shift_clock_oe_o && idle_o |-> !shift_clock_o) else $error("clk idle");
	chk_data_stable:
	assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
		shift_clock_oe_o && $rose(shift_clock_o)
		|-> $stable(data_o) ##1 $stable(data_o)) else $error("data moved");
	chk_pd_block:
	assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
		(idle_o && power_down_i)[*4] |=> idle_o) else $error("pd start");
	chk_sync_once:
	assert property (@(posedge shift_clock_i) disable iff (sys_rst_i)
		sync_o |=> !sync_o) else $error("sync width");
	chk_restart_now:
	assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
		$rose(idle_o) && !rd_conv_i && !$past(rd_conv_i, 4) && !chip_sel_n_i
		&& !power_down_i |-> ##[1:2] !idle_o) else $error("no restart");
endmodule : ssc_chk
bind ssc_sar_serial_control ssc_chk #(.RES_W(RES_W)) u_chk (.*);

// file: testbench/ssc_host_model.sv
// Host model: supplies the link shift clock and collects the stream.
`timescale 1ns/1ns
module ssc_host_model (
	input wire logic run_i,
	input wire logic sync_i,
	input wire logic data_i,
	output logic shift_clock_o,
	output logic [23:0] word_o
);
	// The clock is parked low between frames, as a real host leaves it.
	initial begin
		shift_clock_o = 1'b0;
		word_o = 24'h000000;
		#7;
		forever #15 shift_clock_o = run_i ? ~shift_clock_o : 1'b0;
	end
	// Bits are taken half a period after the edge that launches them.
	always @(negedge shift_clock_o) begin
		word_o <= sync_i ? {23'h000000, data_i} : {word_o[22:0], data_i};
	end
endmodule : ssc_host_model

// file: testbench/testbench.sv
// Self-checking bench for the converter sequencer and serial output.
`timescale 1ns/1ns
module testbench;
	logic clk = 1'b0, rst = 1'b1, rc = 1'b1, cs_n = 1'b1, pd = 1'b0;
	logic fmt = 1'b1, ext = 1'b0, tag = 1'b0, cmp = 1'b0, run = 1'b0;
	logic sck, sck_o, sck_oe, dat, syn, idl, hld;
	logic [15:0] dac, vin = 16'h0000, cap = 16'h0000;
	logic [23:0] word;
	int fail_count = 0, checked = 0, pulses = 0, p;
	initial forever #50 clk = ~clk;
	// A trial bit is kept while the trial code stays at or below vin.
	always @(negedge clk) cmp <= (dac <= vin);
	always @(negedge sck_o) begin
		cap <= {cap[14:0], dat};
		pulses <= pulses + 1;
	end
	ssc_sar_serial_control u_dut (.core_clk_i(clk), .sys_rst_i(rst),
		.rd_conv_i(rc), .chip_sel_n_i(cs_n), .power_down_i(pd),
		.output_format_sel_i(fmt), .shift_clock_source_sel_i(ext),
		.tag_i(tag), .comparator_i(cmp), .shift_clock_i(sck),
		.shift_clock_o(sck_o), .shift_clock_oe_o(sck_oe), .data_o(dat),
		.sync_o(syn), .idle_o(idl), .hold_o(hld), .dac_code_o(dac));
	ssc_host_model u_host (.run_i(run), .sync_i(syn), .data_i(dat),
		.shift_clock_o(sck), .word_o(word));
	task cmp16(input string n, input logic [15:0] e, input logic [15:0] s);
		checked++;
		if (e !== s) begin
			fail_count++;
			$display("Error %s expected %h seen %h", n, e, s);
		end
	endtask : cmp16
	task wait_idle(input logic lvl);
		for (int i = 0; i < 80 && idl !== lvl; i++) @(negedge clk);
		cmp16("idle", {15'h0000, lvl}, {15'h0000, idl});
		cmp16("hold", {15'h0000, ~lvl}, {15'h0000, hld});
	endtask : wait_idle
	task convert(input logic [15:0] v, input logic rel);
		vin = v;
		cs_n = 1'b0;
		rc = 1'b0;
		repeat (5) @(negedge clk);
		rc = 1'b1;
		cs_n = rel;
		wait_idle(1'b0);
		wait_idle(1'b1);
		repeat (20) @(negedge clk);
	endtask : convert
	task wrap_up;
		$display("checked %0d failed %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : wrap_up
	initial begin
		#1000000;
		fail_count++;
		wrap_up;
	end
	initial begin
		repeat (10) @(negedge clk);
		rst = 1'b0;
		convert(16'h1234, 1'b0);
		cmp16("idle data", 16'h0000, {15'h0000, dat});
		tag = 1'b1;
		p = pulses;
		convert(16'h0f0f, 1'b0);
		cmp16("int word", 16'h1234, cap);
		cmp16("pulses", 16'h0010, 16'(pulses - p));
		cmp16("clk dir", 16'h0001, {15'h0000, sck_oe});
		cmp16("idle data", 16'h0001, {15'h0000, dat});
		$display("internal test done");
		pd = 1'b1;
		repeat (3) @(negedge clk);
		rc = 1'b0;
		repeat (10) @(negedge clk);
		cmp16("pd idle", 16'h0001, {15'h0000, idl});
		rc = 1'b1;
		pd = 1'b0;
		repeat (5) @(negedge clk);
		convert(16'h0001, 1'b0);
		cmp16("kept word", 16'h0f0f, cap);
		$display("power down test done");
		rst = 1'b1;
		ext = 1'b1;
		fmt = 1'b0;
		cs_n = 1'b1;
		run = 1'b1;
		repeat (10) @(negedge clk);
		rst = 1'b0;
		run = 1'b0;
		convert(16'h8421, 1'b1);
		run = 1'b1;
		repeat (2) @(negedge clk);
		cs_n = 1'b0;
		@(posedge syn);
		repeat (24) @(negedge sck);
		run = 1'b0;
		// Let the model's last sample settle before it is read.
		@(negedge clk);
		cmp16("link word", 16'h0421, word[23:8]);
		cmp16("clk dir", 16'h0000, {15'h0000, sck_oe});
		cmp16("tag bits", 16'h00ff, {8'h00, word[7:0]});
		$display("external test done");
		rc = 1'b0;
		wait_idle(1'b0);
		wait_idle(1'b1);
		repeat (2) @(negedge clk);
		cmp16("restart", 16'h0000, {15'h0000, idl});
		rc = 1'b1;
		repeat (5) @(negedge clk);
		rc = 1'b0;
		repeat (5) @(negedge clk);
		rc = 1'b1;
		wait_idle(1'b1);
		repeat (3) @(negedge clk);
		cmp16("no restart", 16'h0001, {15'h0000, idl});
		$display("restart test done");
		wrap_up;
	end
endmodule : testbench
